/* File: rtl/sysdesc_pkg.sv */
// constants and types for the system descriptor checker
// Behaviour
// - kind clear and type 2 means local table
// - local table descriptor privilege field ignored
// - local table descriptor only from global table
// - local pointer load only at level 0
// - task types 1,3,9,B decoded
// - gate types 4-7,C,E,F decoded
// - fields split from both descriptor words
// - call gate gives entry and parameter count
// - count used only on privilege change call
// - interrupt/trap handler from selector and offset
// - interrupt gate clears flag, trap keeps
// - task gate uses selector only
// - wrong target kind raises exception 13
// - absent gate raises exception 11
// - system only when kind bit zero
// - task pointer holds current task selector
// - upper half zero means 16-bit style
// - granularity picks bytes or 4K pages
package sysdesc_pkg;

  // *****************************
  // field positions
  // *****************************
  localparam int TYPE_LSB    = 8;
  localparam int TYPE_MSB    = 11;
  localparam int KIND_BIT    = 12;
  localparam int PRIV_LSB    = 13;
  localparam int PRIV_MSB    = 14;
  localparam int PRESENT_BIT = 15;
  localparam int LIMHI_LSB   = 16;
  localparam int LIMHI_MSB   = 19;
  localparam int GRAN_BIT    = 23;
  localparam int BASEHI_LSB  = 24;
  localparam int COUNT_MSB   = 4;
  localparam int PAGE_SHIFT  = 12;
  localparam int LIMLO_MSB   = 15;
  localparam int BASELO_LSB  = 16;
  localparam int BASEMID_MSB = 7;
  localparam int UPPER_LSB   = 16;
  localparam int WORD_MSB    = 31;

  // status bit positions
  localparam int EV_ABSENT   = 0;
  localparam int EV_KIND     = 1;
  localparam int EV_LOAD     = 2;

  // *****************************
  // type codes and constants
  // *****************************
  localparam logic [3:0] T_TASK16_FREE = 4'h1;
  localparam logic [3:0] T_LOCAL_TABLE = 4'h2;
  localparam logic [3:0] T_TASK16_BUSY = 4'h3;
  localparam logic [3:0] T_CALL16      = 4'h4;
  localparam logic [3:0] T_TASK_GATE   = 4'h5;
  localparam logic [3:0] T_INT16       = 4'h6;
  localparam logic [3:0] T_TRAP16      = 4'h7;
  localparam logic [3:0] T_TASK32_FREE = 4'h9;
  localparam logic [3:0] T_TASK32_BUSY = 4'hB;
  localparam logic [3:0] T_CALL32      = 4'hC;
  localparam logic [3:0] T_INT32       = 4'hE;
  localparam logic [3:0] T_TRAP32      = 4'hF;
  localparam logic [1:0] PRIV_TOP      = 2'h0;
  localparam logic [7:0] EXC_ABSENT    = 8'h0B;
  localparam logic [7:0] EXC_PROTECT   = 8'h0D;
  localparam logic [15:0] SEL_RESET    = 16'h0000;

  // register map
  localparam logic [3:0] ADR_STATUS = 4'h0;
  localparam logic [3:0] ADR_MASK   = 4'h1;
  localparam logic [3:0] ADR_TASK   = 4'h2;
  localparam logic [3:0] ADR_LOCAL  = 4'h3;
  localparam logic [3:0] ADR_CLASS  = 4'h4;
  localparam int EV_BITS = 3;

  typedef enum logic [3:0] {
    CLS_INVALID, CLS_LOCAL, CLS_TASK_FREE, CLS_TASK_BUSY,
    CLS_CALL, CLS_TASK_GATE, CLS_INT, CLS_TRAP, CLS_NOT_SYSTEM
  } class_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01
  } phase_type;

  function automatic class_type classify(input logic kind, input logic [3:0] t);
    class_type c;
    c = CLS_INVALID;
    if (kind) begin
      c = CLS_NOT_SYSTEM;
    end else begin
      unique case (t)
        T_LOCAL_TABLE:                 c = CLS_LOCAL;
        T_TASK16_FREE, T_TASK32_FREE:  c = CLS_TASK_FREE;
        T_TASK16_BUSY, T_TASK32_BUSY:  c = CLS_TASK_BUSY;
        T_CALL16, T_CALL32:            c = CLS_CALL;
        T_TASK_GATE:                   c = CLS_TASK_GATE;
        T_INT16, T_INT32:              c = CLS_INT;
        T_TRAP16, T_TRAP32:            c = CLS_TRAP;
        default:                       c = CLS_INVALID;
      endcase
    end
    return c;
  endfunction : classify

endpackage : sysdesc_pkg

/* File: rtl/system_descriptor_checker.sv */
// system descriptor decode and check
`timescale 1ns/1ps
module system_descriptor_checker
  import sysdesc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        desc_valid,
  input  wire logic [31:0] desc_low,
  input  wire logic [31:0] desc_high,
  input  wire logic        from_global_table,
  input  wire logic        load_local_pointer,
  input  wire logic        load_task_pointer,
  input  wire logic [15:0] load_selector,
  input  wire logic [1:0]  current_privilege,
  input  wire logic        priv_change,
  input  wire logic        target_valid,
  input  wire logic        target_kind,
  input  wire logic        target_is_code,
  input  wire logic [3:0]  target_type,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  output logic             irq,
  output logic             result_valid,
  output logic [3:0]       desc_class,
  output logic [31:0]      base_addr,
  output logic [31:0]      limit_bytes,
  output logic             style16,
  output logic [15:0]      dest_selector,
  output logic [31:0]      dest_offset,
  output logic             offset_used,
  output logic [4:0]       param_count,
  output logic             clear_int_flag,
  output logic             fault_valid,
  output logic [7:0]       fault_vector,
  output logic             load_fault,
  output logic [15:0]      task_pointer,
  output logic [15:0]      local_table_pointer
);

  typedef struct packed {
    phase_type         phase;
    logic [31:0]       rdata;
    logic [EV_BITS-1:0] status;
    logic [EV_BITS-1:0] mask;
    logic              res_valid;
    logic [3:0]        cls;
    logic [31:0]       base;
    logic [31:0]       limit;
    logic              s16;
    logic [15:0]       sel;
    logic [31:0]       off;
    logic              off_used;
    logic [4:0]        count;
    logic              clr_if;
    logic              flt;
    logic [7:0]        vec;
    logic              ld_flt;
    logic [15:0]       task_ptr;
    logic [15:0]       local_ptr;
  } state_type;

  state_type s_reg;
  state_type s_next;

  // ******************************
  // helpers
  // ******************************
  // gate kinds carry the presence and target checks
  function automatic logic is_gate(
    input class_type c
  );
    logic g;
    g = (c == CLS_CALL) || (c == CLS_TASK_GATE) || (c == CLS_INT) || (c == CLS_TRAP);
    return g;
  endfunction : is_gate

  // task gates jump by selector alone, the others need an entry offset
  function automatic logic takes_offset(
    input class_type c
  );
    logic o;
    o = (c == CLS_CALL) || (c == CLS_INT) || (c == CLS_TRAP);
    return o;
  endfunction : takes_offset

  function automatic logic is_task_segment(
    input class_type c
  );
    logic ts;
    ts = (c == CLS_TASK_FREE) || (c == CLS_TASK_BUSY);
    return ts;
  endfunction : is_task_segment

  function automatic logic [31:0] join_base(
    input logic [31:0] hi,
    input logic [31:0] lo
  );
    logic [31:0] b;
    b = {hi[WORD_MSB:BASEHI_LSB], hi[BASEMID_MSB:0], lo[WORD_MSB:BASELO_LSB]};
    return b;
  endfunction : join_base

  function automatic logic [19:0] join_limit(
    input logic [31:0] hi,
    input logic [31:0] lo
  );
    logic [19:0] l;
    l = {hi[LIMHI_MSB:LIMHI_LSB], lo[LIMLO_MSB:0]};
    return l;
  endfunction : join_limit

  function automatic logic [31:0] join_offset(
    input logic [31:0] hi,
    input logic [31:0] lo
  );
    logic [31:0] f;
    f = {hi[WORD_MSB:UPPER_LSB], lo[LIMLO_MSB:0]};
    return f;
  endfunction : join_offset

  // page granular limits fill the offset within the page with ones
  function automatic logic [31:0] scale_limit(
    input logic [19:0] l,
    input logic        gran
  );
    logic [31:0] r;
    if (gran) begin
      r = {l, {PAGE_SHIFT{1'b1}}};
    end else begin
      r = 32'(l);
    end
    return r;
  endfunction : scale_limit

  function automatic logic upper_clear(
    input logic [31:0] hi
  );
    logic z;
    z = (hi[WORD_MSB:UPPER_LSB] == '0);
    return z;
  endfunction : upper_clear

  // count matters only for a call gate that changes privilege
  function automatic logic [4:0] pick_count(
    input class_type   c,
    input logic        change,
    input logic [31:0] hi
  );
    logic [4:0] n;
    n = '0;
    if ((c == CLS_CALL) && change) begin
      n = hi[COUNT_MSB:0];
    end
    return n;
  endfunction : pick_count

  function automatic logic [EV_BITS-1:0] clear_ones(
    input logic [EV_BITS-1:0] old,
    input logic [31:0]        w
  );
    logic [EV_BITS-1:0] k;
    k = old & ~w[EV_BITS-1:0];
    return k;
  endfunction : clear_ones

  function automatic logic [EV_BITS-1:0] pack_events(
    input logic absent,
    input logic kind,
    input logic load
  );
    logic [EV_BITS-1:0] e;
    e            = '0;
    e[EV_ABSENT] = absent;
    e[EV_KIND]   = kind;
    e[EV_LOAD]   = load;
    return e;
  endfunction : pack_events

  // unmapped addresses read as zero
  function automatic logic [31:0] read_word(
    input logic [3:0] a,
    input state_type  s
  );
    logic [31:0] r;
    r = '0;
    unique case (a)
      ADR_STATUS: begin
        r = 32'(s.status);
      end
      ADR_MASK: begin
        r = 32'(s.mask);
      end
      ADR_TASK: begin
        r = 32'(s.task_ptr);
      end
      ADR_LOCAL: begin
        r = 32'(s.local_ptr);
      end
      ADR_CLASS: begin
        r = 32'(s.cls);
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction : read_word

  // ******************************
  // decode
  // ******************************
  class_type          cls;
  class_type          tcls;
  logic               present;
  logic [19:0]        lim20;
  logic               gate;
  logic               local_misplaced;
  logic               type_reserved;
  logic               gate_absent;
  logic               target_wrong;
  logic               load_refused;
  logic               absent_ev;
  logic               kind_ev;
  logic               load_ev;

  always_comb begin
    cls             = classify(desc_high[KIND_BIT], desc_high[TYPE_MSB:TYPE_LSB]);
    tcls            = classify(target_kind, target_type);
    present         = desc_high[PRESENT_BIT];
    lim20           = join_limit(desc_high, desc_low);
    gate            = is_gate(cls);
    // privilege field never looked at for local table entries
    local_misplaced = (cls == CLS_LOCAL) && !from_global_table;
    type_reserved   = (cls == CLS_INVALID);
    gate_absent     = gate && !present;
    target_wrong    = 1'b0;
    // target kind is only known when the fetch side looked it up
    if (gate && target_valid) begin
      if (cls == CLS_TASK_GATE) begin
        target_wrong = !is_task_segment(tcls);
      end else begin
        target_wrong = !(target_kind && target_is_code);
      end
    end
    load_refused    = load_local_pointer && (current_privilege != PRIV_TOP);
    absent_ev       = 1'b0;
    kind_ev         = 1'b0;
    load_ev         = 1'b0;
    s_next          = s_reg;
    s_next.res_valid = 1'b0;
    s_next.flt      = 1'b0;
    s_next.ld_flt   = 1'b0;
    s_next.rdata    = '0;
    unique case (s_reg.phase)
      ST_IDLE: begin
        if (desc_valid) begin
          s_next.phase = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!desc_valid) begin
          s_next.phase = ST_IDLE;
        end
      end
    endcase
    // ******************************
    // field capture
    // ******************************
    if (desc_valid) begin
      s_next.res_valid = 1'b1;
      s_next.cls       = cls;
      s_next.base      = join_base(desc_high, desc_low);
      s_next.s16       = upper_clear(desc_high);
      s_next.limit     = scale_limit(lim20, desc_high[GRAN_BIT]);
      s_next.sel       = desc_low[WORD_MSB:BASELO_LSB];
      s_next.off       = join_offset(desc_high, desc_low);
      s_next.off_used  = takes_offset(cls);
      s_next.count     = pick_count(cls, priv_change, desc_high);
      s_next.clr_if    = (cls == CLS_INT);
    end
    // ******************************
    // faults, first hit wins
    // ******************************
    if (desc_valid) begin
      if (local_misplaced || type_reserved) begin
        s_next.flt = 1'b1;
        s_next.vec = EXC_PROTECT;
        kind_ev    = 1'b1;
      end else if (gate_absent) begin
        s_next.flt = 1'b1;
        s_next.vec = EXC_ABSENT;
        absent_ev  = 1'b1;
      end else if (target_wrong) begin
        s_next.flt = 1'b1;
        s_next.vec = EXC_PROTECT;
        kind_ev    = 1'b1;
      end
    end
    // ******************************
    // pointer loads
    // ******************************
    // a refused load leaves the old pointer in place
    if (load_local_pointer) begin
      if (load_refused) begin
        s_next.ld_flt = 1'b1;
        load_ev       = 1'b1;
      end else begin
        s_next.local_ptr = load_selector;
      end
    end
    if (load_task_pointer) begin
      s_next.task_ptr = load_selector;
    end
    // ******************************
    // register port; set wins over clear
    // ******************************
    if (reg_write) begin
      unique case (reg_addr)
        ADR_STATUS: begin
          s_next.status = clear_ones(s_reg.status, reg_wdata);
        end
        ADR_MASK: begin
          s_next.mask = reg_wdata[EV_BITS-1:0];
        end
        default: ;
      endcase
    end
    s_next.status = s_next.status | pack_events(absent_ev, kind_ev, load_ev);
    if (reg_read) begin
      s_next.rdata = read_word(reg_addr, s_reg);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{phase: ST_IDLE, task_ptr: SEL_RESET, local_ptr: SEL_RESET, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata           = s_reg.rdata;
  assign irq                 = |(s_reg.status & s_reg.mask);
  assign result_valid        = s_reg.res_valid;
  assign desc_class          = s_reg.cls;
  assign base_addr           = s_reg.base;
  assign limit_bytes         = s_reg.limit;
  assign style16             = s_reg.s16;
  assign dest_selector       = s_reg.sel;
  assign dest_offset         = s_reg.off;
  assign offset_used         = s_reg.off_used;
  assign param_count         = s_reg.count;
  assign clear_int_flag      = s_reg.clr_if;
  assign fault_valid         = s_reg.flt;
  assign fault_vector        = s_reg.vec;
  assign load_fault          = s_reg.ld_flt;
  assign task_pointer        = s_reg.task_ptr;
  assign local_table_pointer = s_reg.local_ptr;

endmodule : system_descriptor_checker

/* File: verif/sysdesc_properties.sv */
// concurrent checks on the descriptor checker ports
`timescale 1ns/1ps
module sysdesc_properties (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        desc_valid,
  input wire logic [31:0] desc_high,
  input wire logic        priv_change,
  input wire logic        load_local_pointer,
  input wire logic [1:0]  current_privilege,
  input wire logic [3:0]  desc_class,
  input wire logic        style16,
  input wire logic [4:0]  param_count,
  input wire logic        clear_int_flag,
  input wire logic        fault_valid,
  input wire logic [7:0]  fault_vector,
  input wire logic        load_fault
);
  // ****
  // properties
  // ****
  logic [3:0] t;
  logic       sys;
  logic       gate;
  assign t = desc_high[11:8];
  assign sys = desc_valid && !desc_high[12];
  // 4-7,C,E,F are gates; D is the only reserved code with bit 2 set
  assign gate = sys && t[2] && t != 4'hD;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_absent_gate: assert property (gate && !desc_high[15] |=> fault_valid && fault_vector == 8'h0B)
    else $error("absent gate not faulted");
  a_reserved_type: assert property (sys && t inside {4'h0, 4'h8, 4'hA, 4'hD} |=> fault_vector == 8'h0D)
    else $error("reserved type not faulted");
  a_int_clears: assert property (sys && t[2:0] == 3'h6 |=> clear_int_flag)
    else $error("interrupt gate kept flag");
  a_trap_keeps: assert property (sys && t[2:0] == 3'h7 |=> !clear_int_flag)
    else $error("trap gate cleared flag");
  a_count_ignored: assert property (desc_valid && !(sys && t[2:0] == 3'h4 && priv_change) |=> param_count == 5'h00)
    else $error("count used");
  a_kind_bit: assert property (desc_valid && desc_high[12] |=> desc_class == 4'h8)
    else $error("kind bit ignored");
  a_style_flag: assert property (desc_valid |=> style16 == ($past(desc_high[31:16]) == 16'h0000))
    else $error("style flag wrong");
  a_load_refused: assert property (load_local_pointer && current_privilege != 2'h0 |=> load_fault)
    else $error("load not refused");
endmodule : sysdesc_properties

bind system_descriptor_checker sysdesc_properties u_props (.sys_clk(sys_clk), .rst(rst), .desc_valid(desc_valid),
  .desc_high(desc_high), .priv_change(priv_change), .load_local_pointer(load_local_pointer),
  .current_privilege(current_privilege), .desc_class(desc_class), .style16(style16), .param_count(param_count),
  .clear_int_flag(clear_int_flag), .fault_valid(fault_valid), .fault_vector(fault_vector), .load_fault(load_fault));

/* File: verif/desc_fetch_model.sv */
// descriptor fetch and target lookup model
`timescale 1ns/1ps
module desc_fetch_model (
  input  wire logic        sys_clk,
  input  wire logic        req,
  input  wire logic        bad,
  input  wire logic [31:0] lo,
  input  wire logic [31:0] hi,
  output logic             desc_valid = 1'b0,
  output logic [31:0]      desc_low = 32'h0,
  output logic [31:0]      desc_high = 32'h0,
  output logic             target_valid = 1'b0,
  output logic             target_kind = 1'b0,
  output logic             target_is_code = 1'b0,
  output logic [3:0]       target_type = 4'h0
);
  // ****
  // fetch
  // ****
  // released lines flip so stale words never look valid
  always @(posedge sys_clk) begin
    desc_valid <= req;
    target_valid <= req;
    desc_low <= req ? lo : ~desc_low;
    desc_high <= req ? hi : ~desc_high;
    target_kind <= req ? (hi[11:8] == 4'h5) == bad : ~target_kind;
    target_is_code <= req ? hi[11:8] != 4'h5 && !bad : ~target_is_code;
    target_type <= req ? (bad ? 4'h2 : 4'h9) : ~target_type;
  end
endmodule : desc_fetch_model

/* File: verif/tb_system_descriptor_checker.sv */
// random bench for the system descriptor checker
`timescale 1ns/1ps
module tb_system_descriptor_checker;
  import sysdesc_pkg::*;
  // ****
  // bench
  // ****
  logic sys_clk = 0, rst = 1, req = 0, bad = 0, from_global_table = 0, load_local_pointer = 0, p;
  logic load_task_pointer = 0, priv_change = 0, reg_write = 0, reg_read = 0;
  logic desc_valid, target_valid, target_kind, target_is_code, irq, result_valid, style16;
  logic offset_used, clear_int_flag, fault_valid, load_fault;
  logic [31:0] desc_low, desc_high, reg_rdata, base_addr, limit_bytes, dest_offset, lo = 0, hi = 0, reg_wdata = 0;
  logic [15:0] dest_selector, task_pointer, local_table_pointer, load_selector = 0;
  logic [3:0] target_type, desc_class, reg_addr = 0;
  logic [3:0] cls_tab [16] = '{0, 2, 1, 3, 4, 5, 6, 7, 0, 2, 0, 3, 4, 0, 6, 7};
  logic [1:0] current_privilege = 0;
  logic [4:0] param_count;
  logic [7:0] fault_vector;
  int n_fail = 0, samples_checked = 0, i;
  always #4 sys_clk = ~sys_clk;
  desc_fetch_model far (.sys_clk(sys_clk), .req(req), .bad(bad), .lo(lo), .hi(hi), .desc_valid(desc_valid),
    .desc_low(desc_low), .desc_high(desc_high), .target_valid(target_valid), .target_kind(target_kind),
    .target_is_code(target_is_code), .target_type(target_type));
  system_descriptor_checker dut (.sys_clk(sys_clk), .rst(rst), .desc_valid(desc_valid), .desc_low(desc_low),
    .desc_high(desc_high), .from_global_table(from_global_table), .load_local_pointer(load_local_pointer),
    .load_task_pointer(load_task_pointer), .load_selector(load_selector), .current_privilege(current_privilege),
    .priv_change(priv_change), .target_valid(target_valid), .target_kind(target_kind),
    .target_is_code(target_is_code), .target_type(target_type), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .result_valid(result_valid),
    .desc_class(desc_class), .base_addr(base_addr), .limit_bytes(limit_bytes), .style16(style16),
    .dest_selector(dest_selector), .dest_offset(dest_offset), .offset_used(offset_used), .param_count(param_count),
    .clear_int_flag(clear_int_flag), .fault_valid(fault_valid), .fault_vector(fault_vector),
    .load_fault(load_fault), .task_pointer(task_pointer), .local_table_pointer(local_table_pointer));
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task print_verdict;
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // absence is judged before the target lookup
  function automatic logic [7:0] exp_vector(input logic [3:0] c, input logic pr);
    logic [7:0] v;
    v = 8'h00;
    if (c inside {[4:7]} && !pr)
      v = 8'h0B;
    else if (c == 0 || (c == 1 && !from_global_table) || (c inside {[4:7]} && bad))
      v = 8'h0D;
    return v;
  endfunction : exp_vector
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= w;
    reg_read <= !w;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    @(negedge sys_clk);
    if (!w) chk(reg_rdata, d);
  endtask : bus
  // odd types get a zero upper half, so both descriptor styles appear
  task send(input logic [3:0] t, input logic k, input logic pr);
    logic [3:0] c;
    logic [7:0] v;
    @(posedge sys_clk);
    lo <= $urandom;
    hi <= {16'($urandom) & {16{!t[0]}}, pr, 2'($urandom), k, t, 8'($urandom)};
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    c = k ? 4'h8 : cls_tab[t];
    v = exp_vector(c, pr);
    chk(desc_class, c);
    chk({fault_valid, fault_valid ? fault_vector : 8'h00}, {v != 0, v});
    chk({clear_int_flag, offset_used}, {c == 6, c inside {4, 6, 7}});
    chk(param_count, c == 4 && priv_change ? hi[4:0] : 5'h00);
    chk(base_addr, {hi[31:24], hi[7:0], lo[31:16]});
    chk(limit_bytes, hi[23] ? {hi[19:16], lo[15:0], 12'hFFF} : {12'h000, hi[19:16], lo[15:0]});
    chk(dest_offset, {hi[31:16], lo[15:0]});
    chk({result_valid, style16, dest_selector}, {1'b1, hi[31:16] == 16'h0000, lo[31:16]});
  endtask : send
  initial begin
    i = $urandom(34065);
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 64; i++) begin
      @(posedge sys_clk);
      p = i < 16 || $urandom_range(3) != 0;
      from_global_table <= i[4];
      priv_change <= 1'($urandom);
      bad <= i[5] && p && 1'($urandom);
      send(i[3:0], i > 47 && i[1], p);
    end
    @(posedge sys_clk);
    load_selector <= 16'h1234;
    load_local_pointer <= 1'b1;
    @(posedge sys_clk);
    current_privilege <= 2'h3;
    load_selector <= 16'h5678;
    load_task_pointer <= 1'b1;
    @(posedge sys_clk);
    load_local_pointer <= 1'b0;
    load_task_pointer <= 1'b0;
    @(negedge sys_clk);
    chk(load_fault, 1'b1);
    chk({task_pointer, local_table_pointer}, {16'h5678, 16'h1234});
    bus(1'b1, ADR_STATUS, 32'h7);
    bus(1'b1, ADR_MASK, 32'h1);
    bus(1'b0, ADR_MASK, 32'h1);
    bad <= 1'b0;
    send(4'h6, 1'b0, 1'b0);
    bus(1'b0, ADR_CLASS, 32'h6);
    bus(1'b0, ADR_STATUS, 32'h1);
    chk(irq, 1'b1);
    bus(1'b1, ADR_STATUS, 32'h1);
    send(4'h8, 1'b0, 1'b1);
    bus(1'b0, ADR_STATUS, 32'h2);
    chk(irq, 1'b0);
    bus(1'b0, ADR_TASK, 32'h5678);
    bus(1'b0, ADR_LOCAL, 32'h1234);
    bus(1'b0, 4'hF, 32'h0);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    print_verdict;
  end
endmodule : tb_system_descriptor_checker
